//--- hw/gtr_cfg.svh
// Offsets, field positions, reset values and timing counts of the guard block.
`ifndef GTR_CFG_SVH
`define GTR_CFG_SVH

`define GTR_ADDR_STATUS 8'h00
`define GTR_ADDR_PBMODE 8'h04

`define GTR_ST_GEN 0
`define GTR_ST_HRUN 1
`define GTR_ST_PERM 2
`define GTR_ST_SEQERR 3
`define GTR_ST_STATE_LO 4
`define GTR_ST_STATE_HI 8
`define GTR_ST_CAUSE_LO 9
`define GTR_ST_CAUSE_HI 11

`define GTR_PBMODE_RST 8'hFF

`define GTR_OP_GUARD 8'h5F
`define GTR_OP_HALT_RUN 8'h4F
`define GTR_OP_STOP 8'h6F
`define GTR_OP_HALT 8'h7F
`define GTR_OP_NOP 8'hFF

`define GTR_RESET_VECTOR 16'h000C
`define GTR_POST_CYCLES 5'd18
`define GTR_POR_TICKS 8'd16

`define GTR_CLK_HZ 20000000
`define GTR_GUARD_MS 10
`define GTR_GUARD_CYCLES ((`GTR_GUARD_MS * `GTR_CLK_HZ + 999) / 1000)

`endif

//--- hw/gtr_pkg.sv
// Types shared by the guard timer, reset and sleep control block.
package gtr_pkg;

  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_HALT = 5'h02,
    ST_STOP = 5'h04,
    ST_POR = 5'h08,
    ST_POST = 5'h10
  } gtr_state_t;

  typedef enum logic [2:0] {
    CS_NONE = 3'h0,
    CS_SUPPLY = 3'h1,
    CS_STOP = 3'h2,
    CS_GUARD = 3'h3,
    CS_HALT_GUARD = 3'h4
  } gtr_cause_t;

endpackage : gtr_pkg

//--- hw/gtr_ctrl.sv
// Guard timer, power-up reset one-shot and halt/stop control with APB access.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "gtr_cfg.svh"

module gtr_ctrl #(
  parameter int GUARD_CYCLES = `GTR_GUARD_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_good,
  input wire logic rc_osc,
  input wire logic perm_guard_opt,
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic irq_pending,
  input wire logic stop_wake_pin_n,
  output logic core_rst,
  output logic [15:0] fetch_addr,
  output logic cpu_clk_en,
  output logic osc_en,
  output logic flag_wr,
  output logic flag_z,
  output logic flag_s,
  output logic flag_v,
  output logic halt_wake,
  output logic [7:0] port_b_mode
);
  import gtr_pkg::*;

  localparam logic [17:0] GT_LIM = 18'(GUARD_CYCLES - 1);

  gtr_state_t state_reg;
  gtr_state_t state_next;
  gtr_cause_t cause_reg;
  logic sup_s1_reg;
  logic sup_s2_reg;
  logic rc_s1_reg;
  logic rc_s2_reg;
  logic rc_s3_reg;
  logic [7:0] por_cnt_reg;
  logic [4:0] post_cnt_reg;
  logic [17:0] gt_cnt_reg;
  logic guard_en_reg;
  logic halt_run_reg;
  logic perm_reg;
  logic last_nop_reg;
  logic seq_err_reg;
  logic flag_wr_reg;
  logic halt_wake_reg;
  logic [7:0] port_b_mode_reg;
  logic [31:0] prdata_reg;

  // Synchronisers; the first stage feeds only the second.
  always_ff @(posedge clk) begin
    if (srst) begin
      sup_s1_reg <= 1'b0;
      sup_s2_reg <= 1'b0;
      rc_s1_reg <= 1'b0;
      rc_s2_reg <= 1'b0;
      rc_s3_reg <= 1'b0;
    end else begin
      sup_s1_reg <= supply_good;
      sup_s2_reg <= sup_s1_reg;
      rc_s1_reg <= rc_osc;
      rc_s2_reg <= rc_s1_reg;
      rc_s3_reg <= rc_s2_reg;
    end
  end

  wire rc_tick = rc_s2_reg & ~rc_s3_reg;
  wire supply_bad = ~sup_s2_reg;

  wire in_run = (state_reg == ST_RUN);
  wire in_halt = (state_reg == ST_HALT);
  wire in_stop = (state_reg == ST_STOP);
  wire in_por = (state_reg == ST_POR);
  wire in_post = (state_reg == ST_POST);

  wire op_exec = op_valid & in_run;
  wire guard_op = op_exec & (op_code == `GTR_OP_GUARD);
  wire hr_op = op_exec & (op_code == `GTR_OP_HALT_RUN);
  wire sleep_op = op_exec & ((op_code == `GTR_OP_HALT) |
    (op_code == `GTR_OP_STOP));
  // A sleep opcode without a flushed pipeline is refused and flagged.
  wire seq_bad = sleep_op & ~last_nop_reg;
  wire halt_req = op_exec & (op_code == `GTR_OP_HALT) & last_nop_reg;
  wire stop_req = op_exec & (op_code == `GTR_OP_STOP) & last_nop_reg;

  wire guard_active = guard_en_reg & (in_run |
    (in_halt & (halt_run_reg | perm_reg)) |
    (in_stop & perm_reg));
  wire guard_exp = guard_active & (gt_cnt_reg == GT_LIM);
  wire wake_stop = in_stop & ~stop_wake_pin_n;
  // Any of these restarts the one-shot.
  wire trig = supply_bad | wake_stop | guard_exp;
  wire por_done = in_por & rc_tick &
    (por_cnt_reg == (`GTR_POR_TICKS - 8'd1));
  wire post_done = in_post & (post_cnt_reg == (`GTR_POST_CYCLES - 5'd1));

  // Reset is combinational on its causes so the core sees it at once.
  assign core_rst = in_por | in_post | trig;
  assign fetch_addr = `GTR_RESET_VECTOR;
  assign cpu_clk_en = ~(in_halt | in_stop);
  assign osc_en = ~in_stop;
  assign flag_wr = flag_wr_reg;
  assign flag_z = flag_wr_reg;
  // Sign and overflow are always cleared by the guard opcode.
  assign flag_s = 1'b0;
  assign flag_v = 1'b0;
  assign halt_wake = halt_wake_reg;
  assign port_b_mode = port_b_mode_reg;

  always_comb begin
    state_next = state_reg;
    if (trig) begin
      state_next = ST_POR;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (halt_req) begin
            state_next = ST_HALT;
          end else if (stop_req) begin
            state_next = ST_STOP;
          end
        end
        ST_HALT: begin
          if (irq_pending) begin
            state_next = ST_RUN;
          end
        end
        ST_STOP: state_next = ST_STOP;
        ST_POR: begin
          if (por_done) begin
            state_next = ST_POST;
          end
        end
        ST_POST: begin
          if (post_done) begin
            state_next = ST_RUN;
          end
        end
        default: state_next = ST_POR;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_POR;
      cause_reg <= CS_NONE;
    end else begin
      state_reg <= state_next;
      if (supply_bad) begin
        cause_reg <= CS_SUPPLY;
      end else if (wake_stop) begin
        cause_reg <= CS_STOP;
      end else if (guard_exp) begin
        cause_reg <= in_halt ? CS_HALT_GUARD : CS_GUARD;
      end
    end
  end

  // The delay counts slow RC ticks so it runs without the crystal.
  always_ff @(posedge clk) begin
    if (srst || trig || !in_por) begin
      por_cnt_reg <= 8'h00;
    end else if (rc_tick) begin
      por_cnt_reg <= por_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || trig || !in_post) begin
      post_cnt_reg <= 5'h00;
    end else begin
      post_cnt_reg <= post_cnt_reg + 5'h01;
    end
  end

  // The strap is caught while reset is applied, never asynchronously.
  always_ff @(posedge clk) begin
    if (srst) begin
      perm_reg <= perm_guard_opt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || trig) begin
      guard_en_reg <= 1'b0;
    end else if (post_done && perm_reg) begin
      guard_en_reg <= 1'b1;
    end else if (guard_op) begin
      guard_en_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || trig) begin
      gt_cnt_reg <= 18'h00000;
    end else if (guard_op) begin
      gt_cnt_reg <= 18'h00000;
    end else if (guard_active) begin
      gt_cnt_reg <= gt_cnt_reg + 18'h00001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || trig) begin
      halt_run_reg <= 1'b0;
    end else if (hr_op && guard_en_reg) begin
      halt_run_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || trig) begin
      last_nop_reg <= 1'b0;
    end else if (op_exec) begin
      last_nop_reg <= (op_code == `GTR_OP_NOP);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      flag_wr_reg <= 1'b0;
      halt_wake_reg <= 1'b0;
    end else begin
      flag_wr_reg <= guard_op;
      halt_wake_reg <= in_halt & irq_pending & ~trig;
    end
  end

  // APB slave: zero wait states, error on unmapped offsets.
  wire hit_status = (paddr == `GTR_ADDR_STATUS);
  wire hit_pbmode = (paddr == `GTR_ADDR_PBMODE);
  wire apb_hit = hit_status | hit_pbmode;
  wire apb_acc = psel & penable;
  wire apb_wr = apb_acc & pwrite & apb_hit;
  wire seq_clr = apb_wr & hit_status & pwdata[`GTR_ST_SEQERR];
  wire pb_wr = apb_wr & hit_pbmode;

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h00000000;
    status_word[`GTR_ST_GEN] = guard_en_reg;
    status_word[`GTR_ST_HRUN] = halt_run_reg;
    status_word[`GTR_ST_PERM] = perm_reg;
    status_word[`GTR_ST_SEQERR] = seq_err_reg;
    status_word[`GTR_ST_STATE_HI:`GTR_ST_STATE_LO] = state_reg;
    status_word[`GTR_ST_CAUSE_HI:`GTR_ST_CAUSE_LO] = cause_reg;
  end

  wire [31:0] rd_mux = hit_status ? status_word :
    (hit_pbmode ? {24'h000000, port_b_mode_reg} : 32'h00000000);

  assign pready = 1'b1;
  assign pslverr = apb_acc & ~apb_hit;
  assign prdata = prdata_reg;

  // Read data is captured in the setup cycle and held through access.
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_reg <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= rd_mux;
    end
  end

  // A new refusal in the same cycle as the clear keeps the flag set.
  always_ff @(posedge clk) begin
    if (srst) begin
      seq_err_reg <= 1'b0;
    end else if (seq_bad) begin
      seq_err_reg <= 1'b1;
    end else if (seq_clr) begin
      seq_err_reg <= 1'b0;
    end
  end

  // Only resets that are not a stop wake restore the port defaults.
  always_ff @(posedge clk) begin
    if (srst || supply_bad || guard_exp) begin
      port_b_mode_reg <= `GTR_PBMODE_RST;
    end else if (pb_wr && !wake_stop) begin
      port_b_mode_reg <= pwdata[7:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_post_length: assert property (
    (in_por ##1 in_post) |-> ##17 core_rst ##1 !in_post)
    else $error("post-delay not 18 cycles");

  a_guard_expire: assert property (
    guard_exp |=> (in_por && !guard_en_reg && core_rst))
    else $error("guard expiry did not reset");

  a_guard_enable: assert property (
    (guard_op && !guard_en_reg && !trig) |=> guard_en_reg)
    else $error("first guard opcode did not enable");

  a_guard_refresh: assert property (
    (guard_op && guard_en_reg && !trig) |=> (gt_cnt_reg == 18'h00000))
    else $error("guard opcode did not clear counter");

  a_guard_sticky: assert property (
    (guard_en_reg && !trig) |=> guard_en_reg)
    else $error("guard timer disabled without reset");

  a_flags_set: assert property (
    guard_op |=> (flag_wr && flag_z && !flag_s && !flag_v))
    else $error("guard opcode flags wrong");

  a_stop_pause: assert property (
    (in_stop && !perm_reg && !trig) |=> $stable(gt_cnt_reg))
    else $error("software guard counted in stop");

  a_halt_pause: assert property (
    (in_halt && !halt_run_reg && !perm_reg && !trig) |=> $stable(gt_cnt_reg))
    else $error("guard counted in halt without halt-run");

  a_halt_run_noop: assert property (
    (hr_op && !guard_en_reg) |=> !halt_run_reg)
    else $error("halt-run took effect before enable");

  a_perm_enable: assert property (
    (perm_reg && in_post ##1 in_run) |-> guard_en_reg)
    else $error("permanent guard not enabled after reset");

  a_halt_clocks: assert property (
    (halt_req && !trig) |=> (!cpu_clk_en && osc_en) [*2])
    else $error("halt clock gating wrong");

  a_halt_exit: assert property (
    (in_halt && irq_pending && !trig) |=> (in_run && halt_wake))
    else $error("interrupt did not leave halt");

  a_stop_wake: assert property (
    (wake_stop && !supply_bad && !guard_exp) |=> (in_por && osc_en))
    else $error("wake pin did not release stop");

  a_port_keep: assert property (
    (wake_stop && !supply_bad && !guard_exp) |=> $stable(port_b_mode_reg))
    else $error("port mode lost on stop wake");

  a_seq_refuse: assert property (
    (seq_bad && !trig) |=> (in_run && seq_err_reg))
    else $error("unflushed sleep opcode accepted");

  a_low_supply: assert property (
    supply_bad |-> core_rst ##1 in_por)
    else $error("low supply did not reset");

  a_reset_now: assert property (
    $fell(core_rst) |-> $past(post_done))
    else $error("reset released outside post-delay end");

endmodule : gtr_ctrl

`default_nettype wire

//--- tb/gtr_core_model.sv
// Behavioural processor core that issues executed opcodes to the block.
`timescale 1ns/10ps
`default_nettype none
`include "gtr_cfg.svh"
module gtr_core_model (
  input wire logic clk,
  input wire logic core_rst,
  output logic op_valid,
  output logic [7:0] op_code
);
  initial begin
    op_valid = 1'b0;
    op_code = 8'h00;
  end
  // A core held in reset executes nothing, so no pulse is issued then.
  task automatic exec(input logic [7:0] op);
    @(posedge clk);
    op_valid <= !core_rst;
    op_code <= op;
    @(posedge clk);
    op_valid <= 1'b0;
    op_code <= ~op;
  endtask : exec
  task automatic sleep(input logic [7:0] op);
    exec(`GTR_OP_NOP);
    exec(op);
  endtask : sleep
endmodule : gtr_core_model
`default_nettype wire

//--- tb/guard_timer_reset_sleep_ctrl_tb_top.sv
// Self-checking bench for the guard timer, reset and sleep control block.
`timescale 1ns/10ps
`default_nettype none
`include "gtr_cfg.svh"
module guard_timer_reset_sleep_ctrl_tb_top;
  import gtr_pkg::*;
  localparam int GC = 40;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, port_b_mode, op_code, pb;
  logic [31:0] pwdata, prdata, rd, seed;
  logic supply_good, rc_osc, perm_guard_opt, op_valid, irq_pending;
  logic stop_wake_pin_n, core_rst, cpu_clk_en, osc_en, flag_wr, flag_z;
  logic flag_s, flag_v, halt_wake;
  logic [15:0] fetch_addr;
  int err_total, tests_run, cyc, rst_cnt, rst_mark, wake_cnt, flag_cnt, k;

  gtr_ctrl #(.GUARD_CYCLES(GC)) i_dut (.clk, .srst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .supply_good,
    .rc_osc, .perm_guard_opt, .op_valid, .op_code, .irq_pending,
    .stop_wake_pin_n, .core_rst, .fetch_addr, .cpu_clk_en, .osc_en,
    .flag_wr, .flag_z, .flag_s, .flag_v, .halt_wake, .port_b_mode);
  gtr_core_model i_core (.clk, .core_rst, .op_valid, .op_code);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // The RC period is kept off the clock grid so its phase keeps drifting.
  initial begin
    rc_osc = 1'b0;
    forever #83.33 rc_osc = ~rc_osc;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Answers are taken at the rising edge that samples ready high; only the
  // bench timeout ends a wait that never completes.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    logic rdy;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    rdy = 1'b0;
    while (rdy !== 1'b1) begin
      @(posedge clk);
      rdy = pready;
      rd = prdata;
      er = pslverr;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_rst(input logic want, input int lim);
    int n;
    n = 0;
    while (core_rst !== want && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("core_rst", core_rst, want);
  endtask : wait_rst

  task automatic boot();
    wait_rst(1'b0, 400);
    k = rst_cnt - rst_mark;
    chk("por_len", k >= 66 && k <= 110, 1);
    chk("fetch", fetch_addr, `GTR_RESET_VECTOR);
    apb(1'b0, `GTR_ADDR_STATUS, 0);
    chk("state", rd[8:4], ST_RUN);
  endtask : boot

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (core_rst === 1'b1) rst_cnt <= rst_cnt + 1;
    if (halt_wake === 1'b1) wake_cnt <= wake_cnt + 1;
    if (flag_wr === 1'b1) begin
      flag_cnt <= flag_cnt + 1;
      chk("flags", {flag_z, flag_s, flag_v}, 3'b100);
    end
    if (cyc == 30000) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    seed = 42722;
    {err_total, tests_run, cyc, rst_cnt, rst_mark, wake_cnt,
      flag_cnt} = 224'h0;
    {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {supply_good, perm_guard_opt, irq_pending, stop_wake_pin_n} = 4'b1001;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    boot();
    // A fresh reset starts with the supply seen as bad, so cause is supply.
    chk("status", rd, {20'h0, CS_SUPPLY, ST_RUN, 4'h0});
    apb(1'b0, `GTR_ADDR_PBMODE, 0);
    chk("pb_rst", rd, 32'hFF);
    repeat (4) begin
      pb = 8'(rnd());
      apb(1'b1, `GTR_ADDR_PBMODE, {24'h0, pb});
      apb(1'b0, `GTR_ADDR_PBMODE, 0);
      chk("pb_rw", rd, {24'h0, pb});
      chk("pb_err", er, 1'b0);
      chk("pb_pin", {24'h0, port_b_mode}, {24'h0, pb});
    end
    apb(1'b0, 8'h08, 0);
    chk("unmapped_err", er, 1'b1);
    chk("unmapped_rd", rd, 32'h0);
    $display("test registers done");
    i_core.exec(`GTR_OP_HALT_RUN);
    apb(1'b0, `GTR_ADDR_STATUS, 0);
    chk("halt_run", rd[1:0], 2'b00);
    k = flag_cnt;
    i_core.exec(`GTR_OP_GUARD);
    // The pulse is counted one edge after it shows, so wait for the count.
    repeat (2) @(posedge clk);
    chk("flag_pulse", flag_cnt - k, 1);
    apb(1'b0, `GTR_ADDR_STATUS, 0);
    chk("enabled", rd[0], 1);
    k = rst_cnt;
    repeat (6) begin
      i_core.exec(`GTR_OP_GUARD);
      repeat (rnd() % (GC - 8)) @(posedge clk);
    end
    chk("refreshed", rst_cnt - k, 0);
    rst_mark = rst_cnt;
    wait_rst(1'b1, GC + 8);
    boot();
    chk("cause", rd[11:9], CS_GUARD);
    chk("disabled", rd[0], 0);
    $display("test guard done");
    i_core.exec(`GTR_OP_GUARD);
    i_core.exec(`GTR_OP_HALT);
    apb(1'b0, `GTR_ADDR_STATUS, 0);
    chk("unflushed", {rd[8:4], rd[3]}, {ST_RUN, 1'b1});
    apb(1'b1, `GTR_ADDR_STATUS, 32'h8);
    apb(1'b0, `GTR_ADDR_STATUS, 0);
    chk("seq_clear", rd[3], 0);
    k = rst_cnt;
    i_core.sleep(`GTR_OP_HALT);
    @(negedge clk);
    chk("halt_clk", {cpu_clk_en, osc_en}, 2'b01);
    repeat (3 * GC) @(posedge clk);
    chk("halt_pause", rst_cnt - k, 0);
    k = wake_cnt;
    irq_pending <= 1'b1;
    repeat (3) @(posedge clk);
    irq_pending <= 1'b0;
    chk("wake", {(wake_cnt - k) == 1, cpu_clk_en}, 2'b11);
    i_core.exec(`GTR_OP_GUARD);
    i_core.exec(`GTR_OP_HALT_RUN);
    i_core.sleep(`GTR_OP_HALT);
    rst_mark = rst_cnt;
    wait_rst(1'b1, GC + 8);
    boot();
    chk("cause", rd[11:9], CS_HALT_GUARD);
    $display("test halt done");
    pb = 8'(rnd());
    apb(1'b1, `GTR_ADDR_PBMODE, {24'h0, pb});
    i_core.exec(`GTR_OP_GUARD);
    i_core.sleep(`GTR_OP_STOP);
    @(negedge clk);
    chk("stop_osc", {cpu_clk_en, osc_en}, 2'b00);
    k = rst_cnt;
    repeat (3 * GC) @(posedge clk);
    chk("stop_pause", rst_cnt - k, 0);
    rst_mark = rst_cnt;
    stop_wake_pin_n <= 1'b0;
    wait_rst(1'b1, 4);
    stop_wake_pin_n <= 1'b1;
    boot();
    chk("cause", rd[11:9], CS_STOP);
    apb(1'b0, `GTR_ADDR_PBMODE, 0);
    chk("pb_kept", rd, {24'h0, pb});
    $display("test stop done");
    rst_mark = rst_cnt;
    supply_good <= 1'b0;
    wait_rst(1'b1, 4);
    repeat (2) @(posedge clk);
    supply_good <= 1'b1;
    boot();
    chk("cause", rd[11:9], CS_SUPPLY);
    $display("test supply done");
    perm_guard_opt <= 1'b1;
    srst <= 1'b1;
    rst_mark = rst_cnt;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    boot();
    chk("perm", {rd[2], rd[0]}, 2'b11);
    i_core.sleep(`GTR_OP_HALT);
    rst_mark = rst_cnt;
    wait_rst(1'b1, GC + 8);
    boot();
    $display("test permanent done");
    end_of_test();
  end
endmodule : guard_timer_reset_sleep_ctrl_tb_top
`default_nettype wire
